// [logic/spcg_serial_port.sv]
// Function
// - Four clock modes: normal async, double async, sync master, sync slave.
// - In sync mode the clock pin direction picks master or slave clock.
// - Transfer clock pin is idle and undriven in asynchronous modes.
// - Baud counter reloads at zero and on a low divisor byte write.
// - One generator tick per counter zero, rate system clock over divisor+1.
// - Transmitter divides generator ticks by 16, 8 or 2 for bit timing.
// - Receiver recovery uses ticks directly with 16 or 8 states; sync modes sample on the clock edge.
// - Baud generator serves async and master modes, never slave mode.
// - Divisor is twelve bits, high nibble joined to low byte.
// - Bit rate is system clock over factor times divisor plus one.
// - Double speed halves the divider and the receiver samples per bit.
// - Slave clock passes a synchroniser then an edge detector.
// - Synchroniser and edge detector add two system clocks of latency.
// - Sync data sampled on the edge opposite to the change edge.
// - Polarity low: change rising, sample falling; high: the reverse.
// - One-entry transmit buffer lets frames follow with no gap.
// - Two-level receive buffer with frame, overrun and parity error flags.
`timescale 1ns/10ps
`default_nettype none
module spcg_serial_port (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic powerReduce,
  input wire spcg_pkg::spcg_cfg_t cfg,
  input wire logic [spcg_pkg::BAUD_W-9:0] baudDivisorHigh,
  input wire logic [7:0] baudDivisorLow,
  input wire logic baudLowWrite,
  input wire logic [spcg_pkg::DATA_W-1:0] txData,
  input wire logic txWrite,
  output logic txBufferEmpty,
  output logic txFrameDone,
  output spcg_pkg::spcg_rx_word_t rxWord,
  output logic rxValid,
  input wire logic rxRead,
  input wire logic serialRxPin,
  output logic serialTxPin,
  input wire logic transferClockPinIn,
  output logic transferClockPinOut,
  output logic transferClockPinOen
);
  import spcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Level counter and buffer index are sized for two entries
  if (RX_LEVELS != 2) begin : gBadLevels
    $error("spcg_serial_port: receive buffer logic serves two levels only");
  end

  // Frame bit counts are fixed for eight data bits
  if (DATA_W != 8) begin : gBadData
    $error("spcg_serial_port: frame logic serves eight data bits only");
  end

  // High divisor port takes the bits above the low byte
  if (BAUD_W <= 8) begin : gBadBaud
    $error("spcg_serial_port: divisor must be wider than the low byte");
  end

  // Prescaler and recovery counter are four bits wide
  if (FACTOR_NORMAL > 16 || FACTOR_SYNC < 2) begin : gBadFactor
    $error("spcg_serial_port: mode factors must lie between 2 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and decode

  spcg_state_t st;
  spcg_state_t next_st;

  spcg_mode_t mode;
  logic isSync;
  logic isMaster;
  logic [3:0] limit;
  logic [3:0] half;
  logic baudEnable;
  logic baudTick;
  logic [BAUD_W-1:0] divisor;
  logic masterRise;
  logic masterFall;
  logic slaveRise;
  logic slaveFall;
  logic xckRise;
  logic xckFall;
  logic changeEdge;
  logic sampleEdge;
  logic asyncBitTick;
  logic txBitTick;
  logic rxSampleHit;
  logic rxPin;
  logic [3:0] txFrameBits;
  logic [3:0] rxDataBits;
  logic [DATA_W-1:0] rxGotData;
  logic rxGotParity;
  logic txParity;

  assign mode = spcg_mode_of(cfg);
  assign isSync = cfg.syncModeSelect;
  assign isMaster = (mode == SPCG_SYNC_MASTER);
  assign limit = spcg_limit_of(mode);
  assign half = limit >> 1;

  // Slave mode leaves the generator parked in reload
  assign baudEnable = ~powerReduce & (mode != SPCG_SYNC_SLAVE);
  assign divisor = {baudDivisorHigh, baudDivisorLow};

  ////////////////////////////////////////////////////////////////////////////
  // Baud rate generator

  spcg_baud_gen #(
    .BaudWidth(BAUD_W)
  ) uBaud (
    .mclk(mclk),
    .rstn(rstn),
    .enable(baudEnable),
    .reload(baudLowWrite),
    .divisor(divisor),
    .tick(baudTick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer clock edges

  // Master clock toggles on every generator tick, giving the divide by 2
  assign masterRise = isMaster & baudTick & ~st.xckOut;
  assign masterFall = isMaster & baudTick & st.xckOut;

  // Edge detector reads only the second synchroniser stage
  assign slaveRise = st.xckSync[1] & ~st.xckPrev;
  assign slaveFall = ~st.xckSync[1] & st.xckPrev;

  assign xckRise = isMaster ? masterRise : (isSync & slaveRise);
  assign xckFall = isMaster ? masterFall : (isSync & slaveFall);

  assign changeEdge = cfg.syncClockPolarity ? xckFall : xckRise;
  assign sampleEdge = cfg.syncClockPolarity ? xckRise : xckFall;

  ////////////////////////////////////////////////////////////////////////////
  // Bit timing

  // Asynchronous bit every 16 or 8 generator ticks
  assign asyncBitTick = ~isSync & baudTick & (st.preCount == limit);
  assign txBitTick = isSync ? changeEdge : asyncBitTick;

  // Recovery samples in the middle state of each bit period
  assign rxSampleHit = isSync ? sampleEdge : (baudTick & (st.rxCount == half));

  // Stored inverted so the all-zero reset state reads as an idle line, no false start
  assign rxPin = ~st.rxPinSync[1];

  assign txFrameBits = cfg.parityEnable ? FRAME_BITS_PARITY : FRAME_BITS_PLAIN;
  assign rxDataBits = cfg.parityEnable ? RX_BITS_PARITY : RX_BITS_PLAIN;
  assign txParity = (^st.txBuf) ^ cfg.parityOdd;

  // Without parity the data ends one place higher in the collector
  assign rxGotData = cfg.parityEnable ? st.rxShift[DATA_W-1:0] : st.rxShift[DATA_W:1];
  assign rxGotParity = st.rxShift[DATA_W];

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic txLoad;
    logic [1:0] level;
    spcg_rx_word_t word;
    txLoad = 1'b0;
    level = st.rxLevel;
    word = '0;

    next_st = st;
    // Synchroniser carries the inverted pin
    next_st.rxPinSync = {st.rxPinSync[0], ~serialRxPin};
    next_st.xckSync = {st.xckSync[0], transferClockPinIn};
    next_st.xckPrev = st.xckSync[1];
    next_st.txFrameDone = 1'b0;

    // Master clock output; pin stays quiet otherwise
    if (!isMaster) begin
      next_st.xckOut = XCK_IDLE;
    end else if (baudTick) begin
      next_st.xckOut = ~st.xckOut;
    end

    // Prescaler for asynchronous transmit bit timing
    if (isSync) begin
      next_st.preCount = '0;
    end else if (baudTick) begin
      if (st.preCount == limit) begin
        next_st.preCount = '0;
      end else begin
        next_st.preCount = st.preCount + 4'h1;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Transmitter

    unique case (st.txState)
      SPCG_TX_IDLE: begin
        next_st.txLineLow = 1'b0;
        if (txBitTick && st.txBufFull) begin
          txLoad = 1'b1;
        end
      end
      SPCG_TX_SHIFT: begin
        if (txBitTick) begin
          if (st.txBits == txFrameBits) begin
            next_st.txFrameDone = 1'b1;
            if (st.txBufFull) begin
              // Back-to-back frame: start bit follows the stop bit directly
              txLoad = 1'b1;
            end else begin
              next_st.txState = SPCG_TX_IDLE;
              next_st.txLineLow = 1'b0;
            end
          end else begin
            next_st.txLineLow = ~st.txShift[0];
            next_st.txShift = {1'b1, st.txShift[DATA_W+1:1]};
            next_st.txBits = st.txBits + 4'h1;
          end
        end
      end
    endcase

    if (txLoad) begin
      next_st.txState = SPCG_TX_SHIFT;
      next_st.txLineLow = 1'b1;
      next_st.txBits = 4'h1;
      next_st.txShift = {1'b1, cfg.parityEnable ? txParity : 1'b1, st.txBuf};
      next_st.txBufFull = 1'b0;
    end

    // A write in the cycle the buffer empties is kept
    if (txWrite && (!st.txBufFull || txLoad)) begin
      next_st.txBufFull = 1'b1;
      next_st.txBuf = txData;
    end

    //////////////////////////////////////////////////////////////////////////
    // Receiver

    if (st.rxState == SPCG_RX_IDLE || isSync) begin
      next_st.rxCount = '0;
    end else if (baudTick) begin
      if (st.rxCount == limit) begin
        next_st.rxCount = '0;
      end else begin
        next_st.rxCount = st.rxCount + 4'h1;
      end
    end

    unique case (st.rxState)
      SPCG_RX_IDLE: begin
        if (isSync) begin
          if (sampleEdge && !rxPin) begin
            next_st.rxState = SPCG_RX_DATA;
            next_st.rxBits = '0;
          end
        end else if (!rxPin) begin
          next_st.rxState = SPCG_RX_START;
        end
      end
      SPCG_RX_START: begin
        if (rxSampleHit) begin
          // A start bit gone high by mid-bit was noise
          next_st.rxState = rxPin ? SPCG_RX_IDLE : SPCG_RX_DATA;
          next_st.rxBits = '0;
        end
      end
      SPCG_RX_DATA: begin
        if (rxSampleHit) begin
          next_st.rxShift = {rxPin, st.rxShift[DATA_W:1]};
          next_st.rxBits = st.rxBits + 4'h1;
          if (st.rxBits + 4'h1 == rxDataBits) begin
            next_st.rxState = SPCG_RX_STOP;
          end
        end
      end
      SPCG_RX_STOP: begin
        if (rxSampleHit) begin
          next_st.rxState = SPCG_RX_IDLE;
        end
      end
    endcase

    //////////////////////////////////////////////////////////////////////////
    // Receive buffer

    if (rxRead && st.rxLevel != 2'h0) begin
      next_st.rxBuf[0] = st.rxBuf[1];
      next_st.rxBuf[1] = '0;
      level = st.rxLevel - 2'h1;
    end

    // Only the first stop bit is checked
    if (st.rxState == SPCG_RX_STOP && rxSampleHit) begin
      word.data = rxGotData;
      word.frameError = ~rxPin;
      word.parityError = cfg.parityEnable & (rxGotParity ^ (^rxGotData) ^ cfg.parityOdd);
      word.overrun = 1'b0;
      if (level < 2'(RX_LEVELS)) begin
        next_st.rxBuf[level[0]] = word;
        level = level + 2'h1;
      end else begin
        // Buffer full: the new character is lost and the newest entry says so
        next_st.rxBuf[1].overrun = 1'b1;
      end
    end
    next_st.rxLevel = level;

    // Powered-down port holds its reset state
    if (powerReduce) begin
      next_st = SPCG_STATE_RESET;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= SPCG_STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign serialTxPin = ~st.txLineLow;
  assign transferClockPinOut = st.xckOut;
  assign transferClockPinOen = ~isMaster;
  assign txBufferEmpty = ~st.txBufFull;
  assign txFrameDone = st.txFrameDone;
  assign rxWord = st.rxBuf[0];
  assign rxValid = (st.rxLevel != 2'h0);

endmodule
`default_nettype wire

// [common/spcg_pkg.sv]
`default_nettype none
package spcg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int BAUD_W = 12;
  localparam int DATA_W = 8;
  localparam int RX_LEVELS = 2;
  localparam int FACTOR_NORMAL = 16;
  localparam int FACTOR_DOUBLE = 8;
  localparam int FACTOR_SYNC = 2;

  // Last prescaler / recovery state for each mode
  localparam logic [3:0] LIMIT_NORMAL = 4'(FACTOR_NORMAL - 1);
  localparam logic [3:0] LIMIT_DOUBLE = 4'(FACTOR_DOUBLE - 1);
  localparam logic [3:0] LIMIT_SYNC = 4'(FACTOR_SYNC - 1);

  // Frame lengths: start + data (+ parity) + stop
  localparam logic [3:0] FRAME_BITS_PLAIN = 4'hA;
  localparam logic [3:0] FRAME_BITS_PARITY = 4'hB;
  // Bits collected by the receiver before the stop bit
  localparam logic [3:0] RX_BITS_PLAIN = 4'h8;
  localparam logic [3:0] RX_BITS_PARITY = 4'h9;

  localparam logic XCK_IDLE = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SPCG_ASYNC_NORMAL = 2'h0,
    SPCG_ASYNC_DOUBLE = 2'h1,
    SPCG_SYNC_MASTER = 2'h3,
    SPCG_SYNC_SLAVE = 2'h2
  } spcg_mode_t;

  typedef enum logic {
    SPCG_TX_IDLE = 1'b0,
    SPCG_TX_SHIFT = 1'b1
  } spcg_tx_state_t;

  typedef enum logic [1:0] {
    SPCG_RX_IDLE = 2'h0,
    SPCG_RX_START = 2'h1,
    SPCG_RX_DATA = 2'h3,
    SPCG_RX_STOP = 2'h2
  } spcg_rx_state_t;

  typedef struct packed {
    logic syncModeSelect;
    logic doubleSpeedBit;
    logic xferClockPinDirection;
    logic syncClockPolarity;
    logic parityEnable;
    logic parityOdd;
  } spcg_cfg_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic frameError;
    logic parityError;
    logic overrun;
  } spcg_rx_word_t;

  typedef struct packed {
    logic [BAUD_W-1:0] count;
  } spcg_baud_state_t;

  typedef struct packed {
    logic [1:0] rxPinSync;
    logic [1:0] xckSync;
    logic xckPrev;
    logic xckOut;
    logic [3:0] preCount;
    spcg_tx_state_t txState;
    logic txBufFull;
    logic [DATA_W-1:0] txBuf;
    logic [DATA_W+1:0] txShift;
    logic [3:0] txBits;
    logic txLineLow;
    logic txFrameDone;
    spcg_rx_state_t rxState;
    logic [3:0] rxCount;
    logic [3:0] rxBits;
    logic [DATA_W:0] rxShift;
    logic [1:0] rxLevel;
    spcg_rx_word_t [RX_LEVELS-1:0] rxBuf;
  } spcg_state_t;

  localparam spcg_baud_state_t SPCG_BAUD_RESET = '0;
  // All-zero state leaves the line idle high, since the line is stored inverted
  localparam spcg_state_t SPCG_STATE_RESET = '0;

  ////////////////////////////////////////////////////////////////////////////
  // Decoders
  function automatic spcg_mode_t spcg_mode_of(spcg_cfg_t c);
    if (!c.syncModeSelect) begin
      return c.doubleSpeedBit ? SPCG_ASYNC_DOUBLE : SPCG_ASYNC_NORMAL;
    end
    return c.xferClockPinDirection ? SPCG_SYNC_MASTER : SPCG_SYNC_SLAVE;
  endfunction

  function automatic logic [3:0] spcg_limit_of(spcg_mode_t m);
    unique case (m)
      SPCG_ASYNC_NORMAL: return LIMIT_NORMAL;
      SPCG_ASYNC_DOUBLE: return LIMIT_DOUBLE;
      SPCG_SYNC_MASTER: return LIMIT_SYNC;
      SPCG_SYNC_SLAVE: return LIMIT_SYNC;
    endcase
  endfunction

endpackage
`default_nettype wire

// [logic/spcg_baud_gen.sv]
`timescale 1ns/10ps
`default_nettype none
module spcg_baud_gen #(
  parameter int BaudWidth = spcg_pkg::BAUD_W
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic reload,
  input wire logic [BaudWidth-1:0] divisor,
  output logic tick
);
  import spcg_pkg::*;

  if (BaudWidth != BAUD_W) begin : gBadWidth
    $error("spcg_baud_gen: counter width must match the divisor width");
  end

  spcg_baud_state_t st;
  spcg_baud_state_t next_st;

  // One tick per divisor+1 system clocks
  assign tick = enable & (st.count == '0);

  always_comb begin
    next_st = st;
    if (!enable || reload || st.count == '0) begin
      // Held loaded while unused so the first tick after enable is a full period
      next_st.count = divisor;
    end else begin
      next_st.count = st.count - 12'h001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st <= SPCG_BAUD_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule
`default_nettype wire

// [verif/spcg_serial_port_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module spcg_serial_port_properties (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic powerReduce,
  input wire spcg_pkg::spcg_cfg_t cfg,
  input wire logic [spcg_pkg::BAUD_W-9:0] baudDivisorHigh,
  input wire logic [7:0] baudDivisorLow,
  input wire logic baudLowWrite,
  input wire logic txWrite,
  input wire logic txBufferEmpty,
  input wire logic txFrameDone,
  input wire spcg_pkg::spcg_rx_word_t rxWord,
  input wire logic rxValid,
  input wire logic serialTxPin,
  input wire logic transferClockPinIn,
  input wire logic transferClockPinOut,
  input wire logic transferClockPinOen
);
  import spcg_pkg::*;
  logic master;
  logic slave;
  logic toggle;
  logic armed;
  logic prevOut;
  logic chgSeen;
  logic [12:0] gap;
  logic [5:0] xh;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  assign master = cfg.syncModeSelect && cfg.xferClockPinDirection;
  assign slave = cfg.syncModeSelect && !cfg.xferClockPinDirection;
  assign toggle = transferClockPinOut != prevOut;
  // Synchroniser latency may land one cycle either way, so a window of three is allowed
  always_comb begin
    chgSeen = 1'h0;
    for (int i = 1; i < 4; i++) begin
      chgSeen = chgSeen || ((xh[i] != xh[i+1]) && (xh[i] != cfg.syncClockPolarity));
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prevOut <= 1'h0;
      armed <= 1'h0;
      gap <= 13'h0;
      xh <= 6'h0;
    end else begin
      prevOut <= transferClockPinOut;
      // A reload restarts the period, so the next gap is not measured
      armed <= master && !baudLowWrite && !powerReduce && (armed || toggle);
      gap <= toggle ? 13'h0 : gap + 13'h1;
      xh <= {xh[4:0], transferClockPinIn};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_accept;
    txWrite && txBufferEmpty && !powerReduce;
  endsequence
  sequence s_done_tail;
    $past(serialTxPin) ##1 !txFrameDone;
  endsequence
  chk_async_pin_idle: assert property (
    !cfg.syncModeSelect && !$past(cfg.syncModeSelect) |-> transferClockPinOen && !transferClockPinOut)
    else $error("clock pin active in async mode");
  chk_master_drives: assert property (master |-> !transferClockPinOen)
    else $error("master does not drive clock pin");
  chk_slave_no_gen: assert property (
    slave && $past(slave) |-> transferClockPinOen && !transferClockPinOut)
    else $error("generator clock seen in slave mode");
  chk_baud_period: assert property (
    armed && toggle && master |-> gap == {1'h0, baudDivisorHigh, baudDivisorLow})
    else $error("clock period differs from divisor");
  chk_write_fills: assert property (s_accept |=> !txBufferEmpty)
    else $error("write did not fill buffer");
  chk_done_pulse: assert property (txFrameDone |-> s_done_tail)
    else $error("frame done pulse malformed");
  chk_empty_word_zero: assert property (!rxValid |-> rxWord == '0)
    else $error("receive word not clear when empty");
  chk_slave_edge: assert property (
    slave && !powerReduce && $changed(serialTxPin) |-> chgSeen)
    else $error("slave line changed off the change edge");
endmodule
bind spcg_serial_port spcg_serial_port_properties u_props (.mclk, .rstn, .powerReduce, .cfg,
  .baudDivisorHigh, .baudDivisorLow, .baudLowWrite, .txWrite, .txBufferEmpty, .txFrameDone,
  .rxWord, .rxValid, .serialTxPin, .transferClockPinIn, .transferClockPinOut,
  .transferClockPinOen);
`default_nettype wire

// [verif/spcg_remote_node.sv]
`timescale 1ns/10ps
`default_nettype none
module spcg_remote_node (
  input wire logic mclk,
  input wire logic txLine,
  output logic rxLine,
  output logic xckLine
);
  // Period of twelve system clocks stays well below a quarter of mclk
  localparam int XckHalf = 6;
  initial begin
    rxLine = 1'h1;
    xckLine = 1'h0;
  end
  // A low stop bit is cut short so the receiver can discard the false start after it
  task automatic send_async(input logic [7:0] d, input int bitCyc, input logic parEn,
      input logic par, input logic stopBit);
    logic [10:0] f;
    int n;
    f = parEn ? {stopBit, par, d, 1'h0} : {1'h1, stopBit, d, 1'h0};
    n = parEn ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk) rxLine <= f[i];
      repeat ((i == n - 1 && !stopBit) ? bitCyc * 5 / 8 : bitCyc - 1) @(posedge mclk);
    end
    @(posedge mclk) rxLine <= 1'h1;
  endtask
  task automatic xfer_sync(input logic pol, input logic [7:0] d, output logic [9:0] got);
    logic [9:0] f;
    f = {1'h1, d, 1'h0};
    @(posedge mclk) xckLine <= pol;
    repeat (8) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk) xckLine <= !pol;
      rxLine <= f[i];
      repeat (XckHalf) @(posedge mclk);
      got[i] = txLine;
      xckLine <= pol;
      repeat (XckHalf - 1) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import spcg_pkg::*;
  logic mclk = 1'h0;
  logic rstn = 1'h0;
  logic powerReduce = 1'h0;
  spcg_cfg_t cfg = '0;
  logic [3:0] divHigh = 4'h0;
  logic [7:0] divLow = 8'h0;
  logic baudLowWrite = 1'h0;
  logic [7:0] txData = 8'h0;
  logic txWrite = 1'h0;
  logic rxRead = 1'h0;
  logic txBufferEmpty, txFrameDone, rxValid, serialTxPin, rxLine, xckLine, xckOut, xckOen, x0;
  spcg_rx_word_t rxWord;
  logic [9:0] got;
  int failures = 0;
  int nCompared = 0;
  always #2.5 mclk = ~mclk;
  spcg_serial_port u_dut (.mclk, .rstn, .powerReduce, .cfg, .baudDivisorHigh(divHigh),
    .baudDivisorLow(divLow), .baudLowWrite, .txData, .txWrite, .txBufferEmpty, .txFrameDone,
    .rxWord, .rxValid, .rxRead, .serialRxPin(rxLine), .serialTxPin,
    .transferClockPinIn(xckLine), .transferClockPinOut(xckOut), .transferClockPinOen(xckOen));
  spcg_remote_node u_node (.mclk, .txLine(serialTxPin), .rxLine, .xckLine);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic giveVerdict();
    $display("compared %0d mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic waitFor(input int sel, input logic lvl);
    logic v;
    for (int i = 0; i < 2000; i++) begin
      @(posedge mclk);
      #1 v = (sel == 0) ? serialTxPin : (sel == 1) ? rxValid : txBufferEmpty;
      if (v === lvl) begin
        return;
      end
    end
    check("wait", 16'(sel), 16'hFFFF);
    giveVerdict();
  endtask
  task automatic send(input logic [7:0] d);
    @(posedge mclk) txData <= d;
    txWrite <= 1'h1;
    @(posedge mclk) txWrite <= 1'h0;
  endtask
  task automatic setup(input logic [5:0] c, input logic [11:0] dv);
    @(posedge mclk) cfg <= spcg_cfg_t'(c);
    {divHigh, divLow} <= dv;
    baudLowWrite <= 1'h1;
    @(posedge mclk) baudLowWrite <= 1'h0;
  endtask
  // Mid-bit sampling; a wrong bit length drifts out of the bit within the frame
  task automatic checkFrame(input logic [7:0] d, input int bitCyc, input logic pe,
      input logic po, input logic noWait);
    logic [10:0] f;
    f = pe ? {1'h1, ^d ^ po, d, 1'h0} : {2'h3, d, 1'h0};
    if (!noWait) begin
      waitFor(0, 1'h0);
    end
    for (int i = 0; i < (pe ? 11 : 10); i++) begin
      repeat (bitCyc / 2) @(posedge mclk);
      #1 check("tx bit", 16'(serialTxPin), 16'(f[i]));
      repeat (bitCyc - bitCyc / 2) @(posedge mclk);
    end
    #1 check("frame done", 16'(txFrameDone), 16'h1);
  endtask
  task automatic txPair(input logic [7:0] d, input int bitCyc, input logic pe, input logic po);
    send(d);
    fork
      begin
        checkFrame(d, bitCyc, pe, po, 1'h0);
        checkFrame(~d, bitCyc, pe, po, 1'h1);
      end
      begin
        waitFor(2, 1'h1);
        send(~d);
      end
    join
  endtask
  task automatic readRx(input logic [10:0] exp);
    waitFor(1, 1'h1);
    check("rx word", 16'(rxWord), 16'(exp));
    @(posedge mclk) rxRead <= 1'h1;
    @(posedge mclk) rxRead <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'h1;
    @(posedge mclk);
    #1 check("reset", 16'({serialTxPin, txBufferEmpty, rxValid, xckOen}), 16'hD);
    for (int m = 0; m < 2; m++) begin
      setup({2'(m), 2'h0, m[0], 1'h1}, 12'h001);
      txPair(8'hA5, (m == 1) ? 16 : 32, m[0], 1'h1);
    end
    $display("async transmit done");
    setup(6'h00, 12'h001);
    u_node.send_async(8'h96, 32, 1'h0, 1'h0, 1'h1);
    readRx({8'h96, 3'h0});
    for (int i = 1; i < 4; i++) begin
      u_node.send_async(8'(i * 17), 32, 1'h0, 1'h0, 1'h1);
    end
    readRx({8'h11, 3'h0});
    readRx({8'h22, 3'h1});
    u_node.send_async(8'h44, 32, 1'h0, 1'h0, 1'h0);
    readRx({8'h44, 3'h4});
    setup(6'h12, 12'h001);
    u_node.send_async(8'h07, 16, 1'h1, 1'h0, 1'h1);
    readRx({8'h07, 3'h2});
    u_node.send_async(8'h07, 16, 1'h1, 1'h1, 1'h1);
    readRx({8'h07, 3'h0});
    $display("async receive done");
    setup(6'h28, 12'h002);
    txPair(8'h3C, 6, 1'h0, 1'h0);
    // Reloads every second cycle keep a divisor of two from ever reaching zero
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk) baudLowWrite <= 1'h1;
      @(posedge mclk) baudLowWrite <= 1'h0;
      #1 x0 = (i == 1) ? xckOut : x0;
    end
    check("clock held", 16'(xckOut), 16'(x0));
    $display("sync master done");
    for (int p = 0; p < 2; p++) begin
      setup(6'h20 | 6'(p * 4), 12'h002);
      send(8'h5A ^ 8'(p));
      u_node.xfer_sync(p[0], 8'hC6, got);
      check("slave tx", 16'(got), 16'({1'h1, 8'h5A ^ 8'(p), 1'h0}));
      readRx({8'hC6, 3'h0});
    end
    // No slave edges follow, so the word waits in the buffer until power reduction
    send(8'h81);
    #1 check("buffer held", 16'(txBufferEmpty), 16'h0);
    @(posedge mclk) powerReduce <= 1'h1;
    @(posedge mclk) powerReduce <= 1'h0;
    #1 check("power reduce", 16'({txBufferEmpty, serialTxPin, rxValid}), 16'h6);
    $display("sync slave done");
    giveVerdict();
  end
endmodule
`default_nettype wire
